/* File: dma_seq_pkg.sv */
// Shared constants and types for the two-channel DMA request sequencer
`default_nettype none
package dma_seq_pkg;
	localparam int NUM_CH = 2;
	localparam int NUM_PERIPH = 8;
	// Register offsets (byte addresses on the Avalon slave)
	localparam logic [7:0] OFS_SRC = 8'h00;
	localparam logic [7:0] OFS_DST = 8'h04;
	localparam logic [7:0] OFS_CNT = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam logic [7:0] OFS_GLOBAL = 8'h20;
	// Reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [2:0] GLOBAL_RESET = 3'h0;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	// Request source codes
	localparam logic [3:0] RS_EXT_DUAL = 4'h0;
	localparam logic [3:0] RS_EXT_MEM_TO_DEV = 4'h2;
	localparam logic [3:0] RS_EXT_DEV_TO_MEM = 4'h3;
	localparam logic [3:0] RS_AUTO = 4'h4;
	localparam logic [3:0] RS_TIMER0 = 4'h6;
	localparam logic [3:0] RS_TIMER1 = 4'h7;
	localparam logic [3:0] RS_TIMER2 = 4'h8;
	localparam logic [3:0] RS_CONV = 4'hb;
	localparam logic [3:0] RS_SER0_TX = 4'hc;
	localparam logic [3:0] RS_SER0_RX = 4'hd;
	localparam logic [3:0] RS_SER1_TX = 4'he;
	localparam logic [3:0] RS_SER1_RX = 4'hf;
	// Transfer size codes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;
	localparam logic [1:0] SIZE_BAD = 2'h3;

	typedef struct packed {
		logic [3:0] req_source_sel;
		logic [4:0] rsv;
		logic req_sample_sel;
		logic burst_mode;
		logic [1:0] size_sel;
		logic end_irq_enable;
		logic end_flag;
		logic chan_enable;
	} chan_ctrl_t;

	typedef struct packed {
		logic addr_err_flag;
		logic nmi_flag;
		logic master_enable;
	} global_ctrl_t;

	typedef struct packed {
		logic ch;
		logic [31:0] src;
		logic [31:0] dst;
		logic [1:0] size;
		logic single;
		logic dev_to_mem;
	} unit_cmd_t;

	// Peripheral slot for a request code: {valid, index}
	function automatic logic [3:0] periph_slot(input logic [3:0] code);
		unique case (code)
			RS_TIMER0: periph_slot = 4'h8;
			RS_TIMER1: periph_slot = 4'h9;
			RS_TIMER2: periph_slot = 4'ha;
			RS_CONV: periph_slot = 4'hb;
			RS_SER0_TX: periph_slot = 4'hc;
			RS_SER0_RX: periph_slot = 4'hd;
			RS_SER1_TX: periph_slot = 4'he;
			RS_SER1_RX: periph_slot = 4'hf;
			default: periph_slot = 4'h0;
		endcase
	endfunction : periph_slot
endpackage : dma_seq_pkg
`default_nettype wire

/* File: two_channel_dma_request_sequencer.sv */
// Two-channel DMA request sequencer with Avalon-MM register slave
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
module two_channel_dma_request_sequencer #(
	parameter int CNT_W = 24
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Avalon-MM register slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Request sources
	input wire logic [1:0] ext_req_n,
	input wire logic [7:0] periph_irq,
	input wire logic nmi_event,
	output logic [7:0] periph_req_clear,
	output logic [7:0] periph_cpu_irq,
	// Transfer unit port
	output logic unit_valid,
	output dma_seq_pkg::unit_cmd_t unit_cmd,
	input wire logic unit_done,
	input wire logic unit_addr_err,
	output logic [1:0] ext_ack,
	// Completion interrupts
	output logic [1:0] xfer_end_irq
);
	import dma_seq_pkg::*;

	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
		$error("CNT_W must lie between 2 and 32");
	end

	typedef enum logic {ST_IDLE, ST_BUSY} state_t;

	state_t state_reg;
	logic active_reg;
	logic resp_reg;
	logic wr_now;
	logic rd_now;
	logic [31:0] rd_next;
	global_ctrl_t glob_reg;
	logic nmi_arm_reg;
	logic ae_arm_reg;
	chan_ctrl_t ctrl_w [NUM_CH];
	logic [31:0] src_w [NUM_CH];
	logic [31:0] dst_w [NUM_CH];
	logic [CNT_W-1:0] cnt_w [NUM_CH];
	logic [7:0] clr_w [NUM_CH];
	logic [NUM_CH-1:0] ok;
	logic [NUM_CH-1:0] req;
	logic [NUM_CH-1:0] want;
	logic [NUM_CH-1:0] cnt_wr;
	logic grant_any;
	logic gch;
	logic abort_now;
	logic done_ok;
	logic err_evt;
	logic [7:0] routed;

	// Avalon slave: one wait state on every access
	assign avs_waitrequest = (avs_read | avs_write) & ~resp_reg;
	assign wr_now = avs_write & resp_reg;
	assign rd_now = avs_read & resp_reg;

	always_ff @(posedge clock) begin
		if (sys_rst)
			resp_reg <= 1'b0;
		else
			resp_reg <= (avs_read | avs_write) & ~resp_reg;
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		for (int i = 0; i < NUM_CH; i++) begin
			if (avs_address == 8'(i) * CH_STRIDE + OFS_SRC)
				rd_next = src_w[i];
			if (avs_address == 8'(i) * CH_STRIDE + OFS_DST)
				rd_next = dst_w[i];
			if (avs_address == 8'(i) * CH_STRIDE + OFS_CNT)
				rd_next = 32'(cnt_w[i]);
			if (avs_address == 8'(i) * CH_STRIDE + OFS_CTRL)
				rd_next = {16'h0000, ctrl_w[i]};
		end
		if (avs_address == OFS_GLOBAL)
			rd_next = {29'h0, glob_reg};
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & ~resp_reg)
			avs_readdata <= rd_next;
	end

	// Global control: master enable, NMI and address-error flags
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			glob_reg <= global_ctrl_t'(GLOBAL_RESET);
			nmi_arm_reg <= 1'b0;
			ae_arm_reg <= 1'b0;
		end else begin
			if (wr_now && avs_address == OFS_GLOBAL) begin
				glob_reg.master_enable <= avs_writedata[0];
				nmi_arm_reg <= 1'b0;
				ae_arm_reg <= 1'b0;
				if (!avs_writedata[1] && nmi_arm_reg)
					glob_reg.nmi_flag <= 1'b0;
				if (!avs_writedata[2] && ae_arm_reg)
					glob_reg.addr_err_flag <= 1'b0;
			end else if (rd_now && avs_address == OFS_GLOBAL) begin
				nmi_arm_reg <= glob_reg.nmi_flag;
				ae_arm_reg <= glob_reg.addr_err_flag;
			end
			if (nmi_event)
				glob_reg.nmi_flag <= 1'b1;
			if (err_evt)
				glob_reg.addr_err_flag <= 1'b1;
		end
	end

	// Per-channel registers and request detection
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		localparam logic [7:0] BASE = 8'(i) * CH_STRIDE;
		chan_ctrl_t ctrl_reg;
		chan_ctrl_t wd;
		logic [31:0] src_reg;
		logic [31:0] dst_reg;
		logic [CNT_W-1:0] cnt_reg;
		logic end_arm_reg;
		logic ext_prev_reg;
		logic ext_pend_reg;
		logic burst_hold_reg;
		logic irq_reg;
		logic [3:0] slot;
		logic is_ext;
		logic is_periph;
		logic ext_hit;
		logic grant_i;
		logic done_i;
		logic last_i;
		logic wr_ctrl;

		assign wd = chan_ctrl_t'(avs_writedata[15:0]);
		assign slot = periph_slot(ctrl_reg.req_source_sel);
		assign is_periph = slot[3];
		assign is_ext = ctrl_reg.req_source_sel == RS_EXT_DUAL
			|| ctrl_reg.req_source_sel == RS_EXT_MEM_TO_DEV
			|| ctrl_reg.req_source_sel == RS_EXT_DEV_TO_MEM;
		assign wr_ctrl = wr_now && avs_address == BASE + OFS_CTRL;
		assign cnt_wr[i] = wr_now && avs_address == BASE + OFS_CNT;
		assign grant_i = grant_any && gch == 1'(i);
		assign done_i = done_ok && active_reg == 1'(i);
		assign last_i = done_i && cnt_reg == CNT_W'(1);

		assign ok[i] = ctrl_reg.chan_enable && glob_reg.master_enable
			&& !ctrl_reg.end_flag && !glob_reg.nmi_flag
			&& !glob_reg.addr_err_flag
			&& cnt_reg != '0
			&& ctrl_reg.size_sel != SIZE_BAD;

		// Low level or latched falling edge of the request pin
		assign ext_hit = ctrl_reg.req_sample_sel ? ext_pend_reg
			: !ext_req_n[i];

		always_comb begin
			if (ctrl_reg.req_source_sel == RS_AUTO)
				req[i] = 1'b1;
			else if (is_ext)
				req[i] = ext_hit;
			else if (is_periph)
				req[i] = periph_irq[slot[2:0]] | burst_hold_reg;
			else
				req[i] = 1'b0;
		end

		assign want[i] = req[i] & ok[i];

		always_comb begin
			clr_w[i] = 8'h00;
			if (is_periph && ((grant_i && !ctrl_reg.burst_mode)
				|| (last_i && ctrl_reg.burst_mode)))
				clr_w[i][slot[2:0]] = 1'b1;
		end

		always_ff @(posedge clock) begin
			if (sys_rst) begin
				ctrl_reg <= chan_ctrl_t'(CTRL_RESET);
				end_arm_reg <= 1'b0;
			end else begin
				if (wr_ctrl) begin
					ctrl_reg.req_source_sel <= wd.req_source_sel;
					ctrl_reg.req_sample_sel <= wd.req_sample_sel;
					ctrl_reg.burst_mode <= wd.burst_mode;
					ctrl_reg.size_sel <= wd.size_sel;
					ctrl_reg.end_irq_enable <= wd.end_irq_enable;
					ctrl_reg.chan_enable <= wd.chan_enable;
					end_arm_reg <= 1'b0;
					if (!wd.end_flag && end_arm_reg)
						ctrl_reg.end_flag <= 1'b0;
				end else if (rd_now && avs_address == BASE + OFS_CTRL)
					end_arm_reg <= ctrl_reg.end_flag;
				if (last_i)
					ctrl_reg.end_flag <= 1'b1;
			end
		end

		always_ff @(posedge clock) begin
			if (sys_rst) begin
				src_reg <= ADDR_RESET;
				dst_reg <= ADDR_RESET;
				cnt_reg <= '0;
			end else begin
				if (wr_now && avs_address == BASE + OFS_SRC)
					src_reg <= avs_writedata;
				if (wr_now && avs_address == BASE + OFS_DST)
					dst_reg <= avs_writedata;
				if (cnt_wr[i])
					cnt_reg <= avs_writedata[CNT_W-1:0];
				else if (done_i)
					cnt_reg <= cnt_reg - CNT_W'(1);
			end
		end

		always_ff @(posedge clock) begin
			if (sys_rst) begin
				ext_prev_reg <= 1'b1;
				ext_pend_reg <= 1'b0;
			end else begin
				ext_prev_reg <= ext_req_n[i];
				if (ext_prev_reg && !ext_req_n[i])
					ext_pend_reg <= 1'b1;
				else if (grant_i || !ctrl_reg.req_sample_sel)
					ext_pend_reg <= 1'b0;
			end
		end

		always_ff @(posedge clock) begin
			if (sys_rst)
				burst_hold_reg <= 1'b0;
			else if (last_i || !ok[i] || (abort_now && active_reg == 1'(i)))
				burst_hold_reg <= 1'b0;
			else if (grant_i && is_periph && ctrl_reg.burst_mode)
				burst_hold_reg <= 1'b1;
		end

		always_ff @(posedge clock) begin
			if (sys_rst)
				irq_reg <= 1'b0;
			else
				irq_reg <= ctrl_reg.end_flag && ctrl_reg.end_irq_enable;
		end

		assign ctrl_w[i] = ctrl_reg;
		assign src_w[i] = src_reg;
		assign dst_w[i] = dst_reg;
		assign cnt_w[i] = cnt_reg;
		assign xfer_end_irq[i] = irq_reg;
	end

	// Peripheral request routing and automatic clear
	always_comb begin
		routed = 8'h00;
		periph_req_clear = 8'h00;
		for (int i = 0; i < NUM_CH; i++) begin
			if (ctrl_w[i].chan_enable
				&& periph_slot(ctrl_w[i].req_source_sel) > 4'h7)
				routed[3'(periph_slot(ctrl_w[i].req_source_sel))] = 1'b1;
			periph_req_clear = periph_req_clear | clr_w[i];
		end
	end

	assign periph_cpu_irq = periph_irq & ~routed;

	// Arbitration and unit sequencing
	// No grant in the cycle of an NMI, before its flag is visible
	assign grant_any = state_reg == ST_IDLE && want != '0 && !nmi_event;
	assign gch = !want[0];
	assign abort_now = state_reg == ST_BUSY
		&& (!ok[active_reg] || nmi_event);
	assign done_ok = state_reg == ST_BUSY && unit_done && !unit_addr_err
		&& !abort_now;
	assign err_evt = state_reg == ST_BUSY && unit_done && unit_addr_err;
	assign unit_valid = state_reg == ST_BUSY;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			active_reg <= 1'b0;
			unit_cmd <= '0;
			ext_ack <= 2'h0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (grant_any) begin
						state_reg <= ST_BUSY;
						active_reg <= gch;
						unit_cmd.ch <= gch;
						unit_cmd.src <= src_w[gch];
						unit_cmd.dst <= dst_w[gch];
						unit_cmd.size <= ctrl_w[gch].size_sel;
						unit_cmd.single <= ctrl_w[gch].req_source_sel[3:1]
							== 3'h1;
						unit_cmd.dev_to_mem <= ctrl_w[gch].req_source_sel
							== RS_EXT_DEV_TO_MEM;
						ext_ack <= 2'h0;
						ext_ack[gch] <= ctrl_w[gch].req_source_sel[3:1] == 3'h1;
					end
				end
				ST_BUSY: begin
					if (abort_now || unit_done) begin
						state_reg <= ST_IDLE;
						ext_ack <= 2'h0;
					end
				end
			endcase
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_prio;
		state_reg == ST_IDLE && want[0] |=> unit_valid && unit_cmd.ch == 1'b0;
	endproperty
	a_prio: assert property (p_prio) else $error("channel 0 not first");

	property p_start_ok;
		$rose(unit_valid) |-> (unit_cmd.ch ? $past(want[1]) : $past(want[0]));
	endproperty
	a_start_ok: assert property (p_start_ok) else $error("unit without enable");

	property p_dec;
		done_ok && !active_reg && !cnt_wr[0]
			|=> cnt_w[0] == $past(cnt_w[0]) - CNT_W'(1);
	endproperty
	a_dec: assert property (p_dec) else $error("count not decremented");

	property p_end;
		done_ok && cnt_w[active_reg] == CNT_W'(1)
			|=> ctrl_w[$past(active_reg)].end_flag && !unit_valid
			##1 !(unit_valid && unit_cmd.ch == $past(active_reg, 2));
	endproperty
	a_end: assert property (p_end) else $error("no normal end");

	property p_irq;
		ctrl_w[0].end_flag && ctrl_w[0].end_irq_enable |=> xfer_end_irq[0];
	endproperty
	a_irq: assert property (p_irq) else $error("end interrupt missing");

	property p_nmi;
		nmi_event |=> !unit_valid && glob_reg.nmi_flag ##1 !unit_valid;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi did not halt");

	property p_disable;
		unit_valid && !glob_reg.master_enable |=> !unit_valid;
	endproperty
	a_disable: assert property (p_disable) else $error("abort missed");

	property p_bad_code;
		ctrl_w[0].req_source_sel == 4'h9 || ctrl_w[0].req_source_sel == 4'ha
			|-> !req[0];
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("prohibited code");

	property p_routed;
		ctrl_w[0].chan_enable && ctrl_w[0].req_source_sel == RS_TIMER0
			|-> !periph_cpu_irq[0];
	endproperty
	a_routed: assert property (p_routed) else $error("cpu irq leaked");

	property p_abort_keep;
		abort_now && !cnt_wr[active_reg] && !unit_addr_err
			|=> !ctrl_w[$past(active_reg)].end_flag
			&& cnt_w[$past(active_reg)] == $past(cnt_w[active_reg]);
	endproperty
	a_abort_keep: assert property (p_abort_keep) else $error("abort lost count");

	property p_size;
		$rose(unit_valid) |-> unit_cmd.size != SIZE_BAD;
	endproperty
	a_size: assert property (p_size) else $error("prohibited size");

	c_two_req: cover property (want == 2'h3 && state_reg == ST_IDLE);
	c_normal_end: cover property (done_ok && cnt_w[active_reg] == CNT_W'(1));
	c_abort: cover property (abort_now);
	c_periph_clear: cover property (periph_req_clear != 8'h00);
endmodule : two_channel_dma_request_sequencer
`default_nettype wire

/* File: far_side_model.sv */
// Far-side model: transfer unit responder and peripheral request sources
`default_nettype none
module far_side_model (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Transfer unit port
	input wire logic unit_valid,
	input wire logic [3:0] wait_cycles,
	input wire logic fail_next,
	output logic unit_done,
	output logic unit_addr_err,
	// Peripheral request lines
	input wire logic [7:0] periph_raise,
	input wire logic [7:0] periph_req_clear,
	output logic [7:0] periph_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_reg;
	// Answers a unit wait_cycles + 1 clocks after unit_valid rises, with an error when told to
	always_ff @(posedge clock) begin
		if (sys_rst || !unit_valid || unit_done) begin
			cnt_reg <= 4'h0;
			unit_done <= 1'b0;
			unit_addr_err <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
			unit_done <= cnt_reg == wait_cycles;
			unit_addr_err <= fail_next && cnt_reg == wait_cycles;
		end
	end
	// Raised by periph_raise; stands until the transfer clears it
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			periph_irq <= 8'h00;
		end else begin
			periph_irq <= (periph_irq & ~periph_req_clear) | periph_raise;
		end
	end
endmodule : far_side_model
`default_nettype wire

/* File: two_channel_dma_request_sequencer_tb.sv */
// Testbench for the two-channel DMA request sequencer
`default_nettype none
module two_channel_dma_request_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dma_seq_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] ext_req_n = 2'h3;
	logic [7:0] periph_irq, periph_req_clear, periph_cpu_irq;
	logic [7:0] periph_raise = 8'h00;
	logic nmi_event = 1'b0;
	logic unit_valid, unit_done, unit_addr_err;
	logic [3:0] wait_cycles = 4'h2;
	logic fail_next = 1'b0;
	unit_cmd_t cmd, last_cmd;
	logic [1:0] ext_ack, last_ack, xfer_end_irq;
	logic cpu_watch = 1'b0;
	logic cpu_bad = 1'b0;
	logic [31:0] q;
	logic [3:0] codes[8] = '{4'h6, 4'h7, 4'h8, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	logic [3:0] bad[4] = '{4'h1, 4'h5, 4'h9, 4'ha};
	logic [3:0] ext_codes[3] = '{RS_EXT_DUAL, RS_EXT_MEM_TO_DEV,
		RS_EXT_DEV_TO_MEM};
	// Peripheral data register addresses; values arbitrary
	logic [31:0] per_reg[8] = '{32'h0, 32'h0, 32'h0, 32'h4000_0100,
		32'h4000_0200, 32'h4000_0204, 32'h4000_0300, 32'h4000_0304};
	logic [31:0] src_exp, dst_exp;
	int fail_count = 0;
	int tests_run = 0;
	int done_cnt = 0;
	logic order[$];

	always #25 clock = ~clock;

	two_channel_dma_request_sequencer DUT (.clock(clock), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_req_n(ext_req_n), .periph_irq(periph_irq),
		.nmi_event(nmi_event), .periph_req_clear(periph_req_clear),
		.periph_cpu_irq(periph_cpu_irq), .unit_valid(unit_valid),
		.unit_cmd(cmd), .unit_done(unit_done),
		.unit_addr_err(unit_addr_err), .ext_ack(ext_ack),
		.xfer_end_irq(xfer_end_irq));

	far_side_model far (.clock(clock), .sys_rst(sys_rst),
		.unit_valid(unit_valid), .wait_cycles(wait_cycles),
		.fail_next(fail_next), .unit_done(unit_done),
		.unit_addr_err(unit_addr_err), .periph_raise(periph_raise),
		.periph_req_clear(periph_req_clear), .periph_irq(periph_irq));

	// Logs every finished unit
	always @(posedge clock) begin
		if (unit_valid && unit_done) begin
			done_cnt <= done_cnt + 1;
			last_cmd <= cmd;
			last_ack <= ext_ack;
			order.push_back(cmd.ch);
		end
		if (cpu_watch && periph_cpu_irq !== 8'h00)
			cpu_bad <= 1'b1;
	end

	function automatic logic [31:0] ctl(input logic [3:0] c, input logic b,
		input logic s, input logic [1:0] z, input logic i);
		ctl = {16'h0, c, 5'h0, s, b, z, i, 1'b0, 1'b1};
	endfunction : ctl

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		check(32'(n), 32'h2, "bus answer");
		@(posedge clock);
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp, "register read");
	endtask : rd

	task automatic wait_units(input int target);
		int n;
		n = 0;
		while (done_cnt != target && n < 3000) begin
			@(negedge clock);
			n++;
		end
		check(32'(done_cnt), 32'(target), "unit count");
	endtask : wait_units

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	initial begin
		repeat (40000) @(posedge clock);
		fail_count++;
		finish_test();
	end

	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(8'h0c, 32'h0);
		rd(8'h20, 32'h0);
		bus(1'b1, 8'h30, 32'hffff_ffff);
		rd(8'h30, 32'h0);
		bus(1'b1, 8'h08, 32'h3);
		bus(1'b1, 8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_WORD, 1'b1));
		bus(1'b1, 8'h20, 32'h1);
		wait_units(3);
		check({30'h0, last_cmd.size}, {30'h0, SIZE_WORD}, "size");
		rd(8'h08, 32'h0);
		rd(8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_WORD, 1'b1) | 32'h2);
		check({30'h0, xfer_end_irq}, 32'h1, "end irq");
		bus(1'b1, 8'h08, 32'h2);
		repeat (10) @(posedge clock);
		check(32'(done_cnt), 32'h3, "end flag blocks");
		bus(1'b1, 8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_LONG, 1'b0));
		wait_units(5);
		check({30'h0, last_cmd.size}, {30'h0, SIZE_LONG}, "size");
		bus(1'b1, 8'h20, 32'h0);
		rd(8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_LONG, 1'b0) | 32'h2);
		bus(1'b1, 8'h08, 32'h2);
		bus(1'b1, 8'h18, 32'h1);
		bus(1'b1, 8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0));
		bus(1'b1, 8'h1c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0));
		order.delete();
		bus(1'b1, 8'h20, 32'h1);
		wait_units(8);
		check({29'h0, order[0], order[1], order[2]}, 32'h1, "order");
		wait_cycles <= 4'hf;
		bus(1'b1, 8'h20, 32'h0);
		rd(8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0) | 32'h2);
		bus(1'b1, 8'h08, 32'h5);
		bus(1'b1, 8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0));
		bus(1'b1, 8'h20, 32'h1);
		repeat (4) @(posedge clock);
		bus(1'b1, 8'h20, 32'h0);
		repeat (3) @(posedge clock);
		check({31'h0, unit_valid}, 32'h0, "abort");
		rd(8'h08, 32'h5);
		rd(8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0));
		bus(1'b1, 8'h20, 32'h1);
		repeat (4) @(posedge clock);
		nmi_event <= 1'b1;
		@(posedge clock);
		nmi_event <= 1'b0;
		wait_cycles <= 4'h2;
		repeat (3) @(posedge clock);
		check({31'h0, unit_valid}, 32'h0, "nmi abort");
		rd(8'h20, 32'h3);
		rd(8'h08, 32'h5);
		bus(1'b1, 8'h20, 32'h1);
		wait_units(13);
		rd(8'h20, 32'h1);
		bus(1'b1, 8'h20, 32'h0);
		rd(8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0) | 32'h2);
		bus(1'b1, 8'h08, 32'h2);
		bus(1'b1, 8'h0c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0));
		fail_next <= 1'b1;
		bus(1'b1, 8'h20, 32'h1);
		wait_units(14);
		fail_next <= 1'b0;
		repeat (3) @(posedge clock);
		rd(8'h20, 32'h5);
		check({31'h0, unit_valid}, 32'h0, "error abort");
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h20, 32'h1);
		rd(8'h1c, ctl(RS_AUTO, 1'b0, 1'b0, SIZE_BYTE, 1'b0) | 32'h2);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, 8'h1c, 32'h0);
			bus(1'b1, 8'h18, 32'h1);
			bus(1'b1, 8'h1c, ctl(ext_codes[k], 1'b0, 1'b0, SIZE_BYTE, 1'b0));
			ext_req_n <= 2'h1;
			wait_units(15 + k);
			ext_req_n <= 2'h3;
			check({31'h0, last_cmd.single}, 32'(k != 0), "single");
			check({31'h0, last_cmd.dev_to_mem}, 32'(k == 2), "dir");
			check({30'h0, last_ack}, (k != 0) ? 32'h2 : 32'h0, "ack");
			rd(8'h1c, ctl(ext_codes[k], 1'b0, 1'b0, SIZE_BYTE, 1'b0) | 32'h2);
		end
		bus(1'b1, 8'h18, 32'h2);
		bus(1'b1, 8'h1c, ctl(RS_EXT_DUAL, 1'b0, 1'b1, SIZE_BYTE, 1'b0));
		ext_req_n <= 2'h1;
		wait_units(18);
		repeat (10) @(posedge clock);
		check(32'(done_cnt), 32'd18, "edge once");
		ext_req_n <= 2'h3;
		@(posedge clock);
		ext_req_n <= 2'h1;
		wait_units(19);
		ext_req_n <= 2'h3;
		bus(1'b1, 8'h1c, 32'h0);
		cpu_watch <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, 8'h0c, 32'h0);
			bus(1'b1, 8'h08, 32'h1);
			src_exp = (k == 4 || k == 6) ? 32'h0 : per_reg[k];
			dst_exp = (k == 4 || k == 6) ? per_reg[k] : 32'h0;
			bus(1'b1, 8'h00, src_exp);
			bus(1'b1, 8'h04, dst_exp);
			bus(1'b1, 8'h0c, ctl(codes[k], 1'b0, 1'b0, SIZE_BYTE, 1'b0));
			periph_raise <= 8'h1 << k;
			@(posedge clock);
			periph_raise <= 8'h00;
			wait_units(20 + k);
			repeat (2) @(posedge clock);
			check({24'h0, periph_irq}, 32'h0, "steal clear");
			check(last_cmd.src, src_exp, "source");
			check(last_cmd.dst, dst_exp, "destination");
			rd(8'h0c, ctl(codes[k], 1'b0, 1'b0, SIZE_BYTE, 1'b0) | 32'h2);
		end
		cpu_watch <= 1'b0;
		check({31'h0, cpu_bad}, 32'h0, "cpu irq routed");
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h08, 32'h3);
		bus(1'b1, 8'h0c, ctl(RS_TIMER0, 1'b1, 1'b0, SIZE_BYTE, 1'b0));
		periph_raise <= 8'h01;
		@(posedge clock);
		periph_raise <= 8'h00;
		wait_units(29);
		check({31'h0, periph_irq[0]}, 32'h1, "burst hold");
		wait_units(30);
		repeat (2) @(posedge clock);
		check({31'h0, periph_irq[0]}, 32'h0, "burst clear");
		rd(8'h0c, ctl(RS_TIMER0, 1'b1, 1'b0, SIZE_BYTE, 1'b0) | 32'h2);
		periph_raise <= 8'hff;
		ext_req_n <= 2'h0;
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 8'h0c, 32'h0);
			bus(1'b1, 8'h08, 32'h1);
			bus(1'b1, 8'h0c, ctl(bad[k], 1'b0, 1'b0, SIZE_BYTE, 1'b0));
			repeat (10) @(posedge clock);
			check(32'(done_cnt), 32'd30, "bad code");
		end
		bus(1'b1, 8'h0c, 32'h0);
		periph_raise <= 8'h00;
		ext_req_n <= 2'h3;
		repeat (2) @(posedge clock);
		check({24'h0, periph_cpu_irq}, 32'hff, "cpu irq free");
		finish_test();
	end
endmodule : two_channel_dma_request_sequencer_tb
`default_nettype wire
